// ===== design/mdh_diag_handler.sv
`default_nettype none

// Contract
// - request: address, function 08, sub-function, data, checksum bytes
// - sub-function zero echoes the data field, reply equals request
// - restart: reply sent first, then port reinit zeroing event counters
// - port reinit ends within one second; no replies meanwhile
// - restart reply is an exact echo of the request
// - sub-function two returns the 16-bit diagnostic status register
// - sub-function ten zeroes communication counters and diagnostic status
// - conditions still present may set bits or count right after clear
// - clear-counters reply is an exact echo of the request
// - sub-function twelve returns bad-checksum count since restart or clear
// - checksum error counter is 16 bits and wraps, never saturates
module mdh_diag_handler
#(
   parameter int unsigned RESTART_CYCLES = mdh_pkg::RESTART_CYCLES
)
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // node configuration
   input  wire logic [7:0]  own_addr,
   // received frame bytes from the framer
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_first,
   input  wire logic        rx_last,
   // reply bytes toward the transmitter
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   output logic             tx_last,
   input  wire logic        tx_ready,
   // diagnostic status and counters
   input  wire logic [15:0] diag_set,
   output logic      [15:0] diag_status,
   output logic      [15:0] crc_error_count,
   output logic             counters_clear,
   output logic             comm_reinit
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0]  rst_sync_reg;
   logic        rst_n;

   // asynchronous assert, release through two flops
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   mdh_pkg::mdh_state_t state_reg;
   mdh_pkg::mdh_state_t state_next;

   logic [3:0]  rx_cnt_reg;
   logic [3:0]  rx_cnt_next;
   logic [15:0] rx_crc_reg;
   logic [15:0] rx_crc_next;
   logic [7:0]  rx_buf_reg  [0:5];
   logic [7:0]  rx_buf_next [0:5];

   logic [7:0]  reply_reg   [0:5];
   logic [7:0]  reply_next  [0:5];
   logic [3:0]  tx_idx_reg;
   logic [3:0]  tx_idx_next;
   logic [3:0]  tx_len_reg;
   logic [3:0]  tx_len_next;
   logic [15:0] tx_crc_reg;
   logic [15:0] tx_crc_next;
   logic [7:0]  tx_byte_reg;
   logic [7:0]  tx_byte_next;
   logic        restart_pend_reg;
   logic        restart_pend_next;
   logic [31:0] wait_cnt_reg;
   logic [31:0] wait_cnt_next;
   logic [15:0] diag_reg;
   logic [15:0] diag_next;
   logic [15:0] crc_err_reg;
   logic [15:0] crc_err_next;
   logic        clear_reg;
   logic        clear_next;

   logic        rx_take;
   logic [3:0]  rx_idx;
   logic [3:0]  rx_len;
   logic [15:0] rx_crc_base;
   logic [15:0] rx_crc_step;
   logic        frame_done;
   logic        crc_bad;
   logic        req_ok;
   logic [15:0] tx_crc_step;

   // ----------------------------------------------------------------
   // checksum steps for the receive and transmit paths
   // ----------------------------------------------------------------
   mdh_crc16 u_rx_crc
   (
      .crc_in  (rx_crc_base),
      .crc_out (rx_crc_step),
      .data_in (rx_data)
   );

   mdh_crc16 u_tx_crc
   (
      .crc_in  (tx_crc_reg),
      .crc_out (tx_crc_step),
      .data_in (tx_byte_reg)
   );

   // ----------------------------------------------------------------
   // frame receive
   // ----------------------------------------------------------------
   // bytes are only taken while idle or collecting; during exec, send
   // and reinit the framer's bytes are dropped, no back-pressure exists
   always_comb
   begin
      rx_take     = rx_valid &&
                    ((state_reg == mdh_pkg::ST_RECV) ||
                     ((state_reg == mdh_pkg::ST_IDLE) && rx_first));
      rx_idx      = rx_first ? 4'h0 : rx_cnt_reg;
      rx_len      = (rx_idx == mdh_pkg::CNT_MAX) ? mdh_pkg::CNT_MAX
                                                 : rx_idx + 4'h1;
      rx_crc_base = rx_first ? mdh_pkg::CRC_INIT : rx_crc_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_crc_next = rx_crc_reg;
      rx_buf_next = rx_buf_reg;
      if (rx_take)
      begin
         rx_cnt_next = rx_len;
         rx_crc_next = rx_crc_step;
         if (rx_idx < mdh_pkg::HDR_BYTES)
            rx_buf_next[rx_idx[2:0]] = rx_data;
      end
      frame_done = rx_take && rx_last;
      // whole-frame checksum including its own two bytes leaves zero
      crc_bad    = frame_done && (rx_len >= mdh_pkg::MIN_LEN) &&
                   (rx_crc_step != mdh_pkg::CRC_RESIDUE);
      req_ok     = frame_done && !crc_bad &&
                   (rx_len == mdh_pkg::REQ_LEN) &&
                   (rx_buf_reg[mdh_pkg::POS_ADDR] == own_addr) &&
                   (rx_buf_reg[mdh_pkg::POS_FC] == mdh_pkg::FC_DIAG);
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_cnt_reg <= 4'h0;
         rx_crc_reg <= mdh_pkg::CRC_INIT;
         for (int i = 0; i < 6; i++)
            rx_buf_reg[i] <= 8'h00;
      end
      else
      begin
         rx_cnt_reg <= rx_cnt_next;
         rx_crc_reg <= rx_crc_next;
         rx_buf_reg <= rx_buf_next;
      end
   end

   // ----------------------------------------------------------------
   // command execution, reply and port reinit
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [15:0] sub_code;
      logic        clr_now;
      logic [15:0] crc_upd;
      logic [3:0]  idx_n;
      logic [3:0]  crc_pos;
      sub_code          = {rx_buf_reg[mdh_pkg::POS_SUB_HI],
                           rx_buf_reg[mdh_pkg::POS_SUB_LO]};
      clr_now           = 1'b0;
      crc_upd           = tx_crc_reg;
      idx_n             = tx_idx_reg + 4'h1;
      crc_pos           = tx_len_reg - 4'h2;
      state_next        = state_reg;
      reply_next        = reply_reg;
      tx_idx_next       = tx_idx_reg;
      tx_len_next       = tx_len_reg;
      tx_crc_next       = tx_crc_reg;
      tx_byte_next      = tx_byte_reg;
      restart_pend_next = restart_pend_reg;
      wait_cnt_next     = wait_cnt_reg;

      case (state_reg)
         mdh_pkg::ST_IDLE:
         begin
            if (rx_take && !rx_last)
               state_next = mdh_pkg::ST_RECV;
         end
         mdh_pkg::ST_RECV:
         begin
            if (req_ok)
               state_next = mdh_pkg::ST_EXEC;
            else if (frame_done)
               state_next = mdh_pkg::ST_IDLE;
         end
         mdh_pkg::ST_EXEC:
         begin
            // start from an exact copy of the request header
            reply_next  = rx_buf_reg;
            tx_len_next = mdh_pkg::REQ_LEN;
            case (sub_code)
               mdh_pkg::SUB_LOOPBACK:
                  tx_len_next = mdh_pkg::REQ_LEN;
               mdh_pkg::SUB_RESTART:
                  restart_pend_next = 1'b1;
               mdh_pkg::SUB_DIAG_REG:
               begin
                  reply_next[mdh_pkg::POS_DATA_HI] = diag_reg[15:8];
                  reply_next[mdh_pkg::POS_DATA_LO] = diag_reg[7:0];
               end
               mdh_pkg::SUB_CLEAR:
                  clr_now = 1'b1;
               mdh_pkg::SUB_CRC_ERRORS:
               begin
                  reply_next[mdh_pkg::POS_DATA_HI] = crc_err_reg[15:8];
                  reply_next[mdh_pkg::POS_DATA_LO] = crc_err_reg[7:0];
               end
               default:
               begin
                  // no side effect, short exception frame
                  reply_next[mdh_pkg::POS_FC] =
                     mdh_pkg::FC_DIAG | mdh_pkg::FC_EXC_FLAG;
                  reply_next[mdh_pkg::POS_SUB_HI] =
                     mdh_pkg::EXC_ILLEGAL_FUNCTION;
                  tx_len_next = mdh_pkg::EXC_LEN;
               end
            endcase
            tx_idx_next  = 4'h0;
            tx_crc_next  = mdh_pkg::CRC_INIT;
            tx_byte_next = rx_buf_reg[mdh_pkg::POS_ADDR];
            state_next   = mdh_pkg::ST_SEND;
         end
         mdh_pkg::ST_SEND:
         begin
            if (tx_ready)
            begin
               // checksum covers payload bytes only, low byte goes first
               if (tx_idx_reg < crc_pos)
                  crc_upd = tx_crc_step;
               tx_crc_next = crc_upd;
               tx_idx_next = idx_n;
               if (idx_n < crc_pos)
                  tx_byte_next = reply_reg[idx_n[2:0]];
               else if (idx_n == crc_pos)
                  tx_byte_next = crc_upd[7:0];
               else
                  tx_byte_next = crc_upd[15:8];
               if (tx_last)
               begin
                  if (restart_pend_reg)
                  begin
                     // reply is fully out before the port goes down
                     restart_pend_next = 1'b0;
                     clr_now           = 1'b1;
                     wait_cnt_next     = 32'h0;
                     state_next        = mdh_pkg::ST_REINIT;
                  end
                  else
                     state_next = mdh_pkg::ST_IDLE;
               end
            end
         end
         mdh_pkg::ST_REINIT:
         begin
            // port held down, requests dropped until the time is up
            wait_cnt_next = wait_cnt_reg + 32'h1;
            if (wait_cnt_reg >= 32'(RESTART_CYCLES - 1))
               state_next = mdh_pkg::ST_IDLE;
         end
         default:
            state_next = mdh_pkg::ST_IDLE;
      endcase

      // a condition still present sets again over the clear
      diag_next    = (clr_now ? 16'h0000 : diag_reg) | diag_set;
      crc_err_next = (clr_now ? 16'h0000 : crc_err_reg) +
                     {15'h0000, crc_bad};
      clear_next   = clr_now;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg        <= mdh_pkg::ST_IDLE;
         tx_idx_reg       <= 4'h0;
         tx_len_reg       <= mdh_pkg::REQ_LEN;
         tx_crc_reg       <= mdh_pkg::CRC_INIT;
         tx_byte_reg      <= 8'h00;
         restart_pend_reg <= 1'b0;
         wait_cnt_reg     <= 32'h0;
         diag_reg         <= mdh_pkg::DIAG_STATUS_RESET;
         crc_err_reg      <= mdh_pkg::CRC_ERR_RESET;
         clear_reg        <= 1'b0;
         for (int i = 0; i < 6; i++)
            reply_reg[i] <= 8'h00;
      end
      else
      begin
         state_reg        <= state_next;
         tx_idx_reg       <= tx_idx_next;
         tx_len_reg       <= tx_len_next;
         tx_crc_reg       <= tx_crc_next;
         tx_byte_reg      <= tx_byte_next;
         restart_pend_reg <= restart_pend_next;
         wait_cnt_reg     <= wait_cnt_next;
         diag_reg         <= diag_next;
         crc_err_reg      <= crc_err_next;
         clear_reg        <= clear_next;
         reply_reg        <= reply_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // handshake is combinational from state, data straight from flops
   assign tx_valid        = (state_reg == mdh_pkg::ST_SEND);
   assign tx_data         = tx_byte_reg;
   assign tx_last         = tx_valid && (tx_idx_reg == tx_len_reg - 4'h1);
   assign diag_status     = diag_reg;
   assign crc_error_count = crc_err_reg;
   assign counters_clear  = clear_reg;
   assign comm_reinit     = (state_reg == mdh_pkg::ST_REINIT);

endmodule

`default_nettype wire

// ===== inc/mdh_pkg.sv
`default_nettype none

// ----------------------------------------------------------------
// diagnostics handler constants
// ----------------------------------------------------------------
package mdh_pkg;

   // clock rate and port restart time
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned RESTART_TIME_MS = 1000;
   // longest time, so the division rounds down
   localparam int unsigned RESTART_CYCLES  =
      (CLK_HZ / 1000) * RESTART_TIME_MS;

   // function codes and exception code
   localparam logic [7:0] FC_DIAG              = 8'h08;
   localparam logic [7:0] FC_EXC_FLAG          = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;

   // sub-function codes
   localparam logic [15:0] SUB_LOOPBACK   = 16'h0000;
   localparam logic [15:0] SUB_RESTART    = 16'h0001;
   localparam logic [15:0] SUB_DIAG_REG   = 16'h0002;
   localparam logic [15:0] SUB_CLEAR      = 16'h000a;
   localparam logic [15:0] SUB_CRC_ERRORS = 16'h000c;

   // diagnostic status register (register address 700)
   localparam logic [15:0] DIAG_STATUS_ADDR  = 16'h02bc;
   localparam logic [15:0] DIAG_STATUS_RESET = 16'h0000;
   localparam logic [15:0] CRC_ERR_RESET     = 16'h0000;

   // frame checksum
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   // byte positions inside a request frame
   localparam logic [2:0] POS_ADDR    = 3'h0;
   localparam logic [2:0] POS_FC      = 3'h1;
   localparam logic [2:0] POS_SUB_HI  = 3'h2;
   localparam logic [2:0] POS_SUB_LO  = 3'h3;
   localparam logic [2:0] POS_DATA_HI = 3'h4;
   localparam logic [2:0] POS_DATA_LO = 3'h5;
   localparam logic [3:0] HDR_BYTES   = 4'h6;

   // frame lengths in bytes
   localparam logic [3:0] REQ_LEN = 4'h8;
   localparam logic [3:0] EXC_LEN = 4'h5;
   localparam logic [3:0] MIN_LEN = 4'h4;
   localparam logic [3:0] CNT_MAX = 4'hf;

   // handler states, gray along idle-recv-exec-send-reinit
   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'h0,
      ST_RECV   = 3'h1,
      ST_EXEC   = 3'h3,
      ST_SEND   = 3'h2,
      ST_REINIT = 3'h6
   } mdh_state_t;

endpackage

`default_nettype wire

// ===== design/mdh_crc16.sv
`default_nettype none

// ----------------------------------------------------------------
// one-byte step of the frame checksum, lsb first, reflected poly
// ----------------------------------------------------------------
module mdh_crc16
(
   // running checksum in and out
   input  wire logic [15:0] crc_in,
   output logic      [15:0] crc_out,
   // byte folded in
   input  wire logic [7:0]  data_in
);

   // eight shift steps; purely combinational so one instance per path
   always_comb
   begin
      logic [15:0] c;
      c = crc_in ^ {8'h00, data_in};
      for (int i = 0; i < 8; i++)
      begin
         if (c[0])
            c = (c >> 1) ^ mdh_pkg::CRC_POLY;
         else
            c = c >> 1;
      end
      crc_out = c;
   end

endmodule

`default_nettype wire

// ===== testbench/mdh_diag_handler_assertions.sv
`default_nettype none

// ----------------------------------------------------------------
// port checks for the diagnostics handler
// ----------------------------------------------------------------
module mdh_diag_checker
#(
   parameter int unsigned RESTART_CYCLES = 20
)
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_b,
   // request side
   input wire logic [7:0]  own_addr,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_first,
   input wire logic        rx_last,
   // reply side
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   input wire logic        tx_ready,
   // status and counters
   input wire logic [15:0] diag_set,
   input wire logic [15:0] diag_status,
   input wire logic [15:0] crc_error_count,
   input wire logic        counters_clear,
   input wire logic        comm_reinit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   logic [31:0] rc_reg;
   logic [31:0] rc_next;
   logic [1:0]  up_reg;
   logic [1:0]  up_next;

   // reinit length, and edges since reset to mask the two-flop lag
   always_comb
   begin
      rc_next = comm_reinit ? rc_reg + 32'h1 : 32'h0;
      up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rc_reg <= 32'h0;
         up_reg <= 2'h0;
      end
      else
      begin
         rc_reg <= rc_next;
         up_reg <= up_next;
      end
   end

   reply_start_a: assert property (
      $rose(tx_valid) |-> tx_data == own_addr && $past(rx_valid && rx_last, 2))
      else $error("reply not led by address two cycles after last byte");
   tx_hold_a: assert property (
      tx_valid && !tx_ready
         |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("reply byte changed before it was taken");
   reinit_after_a: assert property (
      $rose(comm_reinit) |-> $past(tx_valid && tx_ready && tx_last)
         && counters_clear)
      else $error("reinit did not follow the last reply byte");
   reinit_quiet_a: assert property (
      comm_reinit |-> !tx_valid)
      else $error("reply offered during reinit");
   reinit_bound_a: assert property (
      comm_reinit |-> rc_reg < RESTART_CYCLES)
      else $error("reinit too long");
   reinit_len_a: assert property (
      $fell(comm_reinit) |-> rc_reg == RESTART_CYCLES)
      else $error("reinit length wrong");
   clear_pulse_a: assert property (
      counters_clear |=> !counters_clear)
      else $error("counter clear longer than one cycle");
   diag_zero_a: assert property (
      ($past(diag_status) & ~diag_status) != 16'h0 |-> ##[0:1] counters_clear)
      else $error("diagnostic bit dropped without a clear");
   diag_sticky_a: assert property (
      up_reg == 2'h3 && diag_set != 16'h0
         |=> (diag_status & $past(diag_set)) == $past(diag_set))
      else $error("diagnostic bit not set by its source");
   crc_step_a: assert property (
      $changed(crc_error_count) |-> crc_error_count <= 16'h1
         || crc_error_count == $past(crc_error_count) + 16'h1)
      else $error("checksum error count moved by more than one");
endmodule

bind mdh_diag_handler mdh_diag_checker
#(
   .RESTART_CYCLES (RESTART_CYCLES)
)
mdh_diag_checker_inst
(
   .mclk (mclk), .rst_b (rst_b), .own_addr (own_addr),
   .rx_valid (rx_valid), .rx_data (rx_data), .rx_first (rx_first),
   .rx_last (rx_last), .tx_valid (tx_valid), .tx_data (tx_data),
   .tx_last (tx_last), .tx_ready (tx_ready), .diag_set (diag_set),
   .diag_status (diag_status), .crc_error_count (crc_error_count),
   .counters_clear (counters_clear), .comm_reinit (comm_reinit)
);

`default_nettype wire

// ===== testbench/mdh_master_model.sv
`default_nettype none

// ----------------------------------------------------------------
// bus master model: sends requests, collects replies
// ----------------------------------------------------------------
module mdh_master_model
(
   // clock
   input  wire logic       mclk,
   // request bytes toward the handler
   output var  logic       rx_valid = 1'b0,
   output var  logic [7:0] rx_data  = 8'h00,
   output var  logic       rx_first = 1'b0,
   output var  logic       rx_last  = 1'b0,
   // reply bytes from the handler
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       tx_ready = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] frm [8];
   logic [7:0] got [$];
   logic       slow = 1'b0;

   // slow mode drops ready every other cycle to exercise the hold
   always @(posedge mclk)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         got.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end

   // reflected checksum over the first n bytes of frm
   function automatic logic [15:0] crc16(input int n);
      logic [15:0] c;
      c = mdh_pkg::CRC_INIT;
      for (int i = 0; i < n; i++)
      begin
         c = c ^ {8'h00, frm[i]};
         for (int b = 0; b < 8; b++)
            c = c[0] ? (c >> 1) ^ mdh_pkg::CRC_POLY : c >> 1;
      end
      return c;
   endfunction

   // lay out a frame, checksum low byte first
   task automatic build(input logic [7:0] a, input logic [7:0] fc,
                        input logic [15:0] sub, input logic [15:0] dat);
      logic [15:0] c;
      frm[0] = a;
      frm[1] = fc;
      frm[2] = sub[15:8];
      frm[3] = sub[7:0];
      frm[4] = dat[15:8];
      frm[5] = dat[7:0];
      c = crc16(6);
      frm[6] = c[7:0];
      frm[7] = c[15:8];
   endtask

   // bytes back to back; idle line never repeats the last byte
   task automatic send(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk);
         rx_valid <= 1'b1;
         rx_data  <= frm[i];
         rx_first <= (i == 0);
         rx_last  <= (i == n - 1);
      end
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      rx_last  <= 1'b0;
      rx_data  <= ~frm[n - 1];
   endtask
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none

`define chk(nm, g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("unexpected %s: expected %h seen %h", nm, e, g); \
      end \
   end

// ----------------------------------------------------------------
// diagnostics handler testbench
// ----------------------------------------------------------------
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned RC   = 20;
   localparam logic [7:0]  ADDR = 8'h4d;
   // codes the handler does not know, one with a nonzero high byte
   localparam logic [15:0] BAD_SUB [3] = '{16'h0003, 16'h000b, 16'h8000};

   logic        mclk     = 1'b0;
   logic        rst_b    = 1'b0;
   logic [15:0] diag_set = 16'h0;
   logic        rx_valid, rx_first, rx_last, tx_valid, tx_last, tx_ready;
   logic [7:0]  rx_data, tx_data;
   logic [15:0] diag_status, crc_error_count;
   logic        counters_clear, comm_reinit;
   int          fails = 0;
   int          num_checks = 0;
   int          clr_cnt = 0;

   mdh_diag_handler #(.RESTART_CYCLES (RC)) mdh_diag_handler_inst
   (
      .mclk (mclk), .rst_b (rst_b), .own_addr (ADDR),
      .rx_valid (rx_valid), .rx_data (rx_data), .rx_first (rx_first),
      .rx_last (rx_last), .tx_valid (tx_valid), .tx_data (tx_data),
      .tx_last (tx_last), .tx_ready (tx_ready), .diag_set (diag_set),
      .diag_status (diag_status), .crc_error_count (crc_error_count),
      .counters_clear (counters_clear), .comm_reinit (comm_reinit)
   );

   mdh_master_model mdh_master_model_inst
   (
      .mclk (mclk), .rx_valid (rx_valid), .rx_data (rx_data),
      .rx_first (rx_first), .rx_last (rx_last), .tx_valid (tx_valid),
      .tx_data (tx_data), .tx_ready (tx_ready)
   );

   // clock and clear-pulse tally
   initial
   begin
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk)
      if (counters_clear === 1'b1)
         clr_cnt <= clr_cnt + 1;

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // one request; bad inverts the low checksum byte
   task automatic req(input logic [15:0] sub, input logic [15:0] dat,
                      input logic [7:0] a, input logic bad);
      mdh_master_model_inst.build(a, mdh_pkg::FC_DIAG, sub, dat);
      if (bad)
         mdh_master_model_inst.frm[6] = ~mdh_master_model_inst.frm[6];
      mdh_master_model_inst.got.delete();
      mdh_master_model_inst.send(8);
   endtask

   // expected reply built fresh, then compared byte by byte
   task automatic reply(input logic [15:0] sub, input logic [15:0] dat,
                        input logic exc);
      int          n;
      logic [15:0] c;
      logic [7:0]  got_b;
      logic [7:0]  exp_b;
      n = exc ? 5 : 8;
      mdh_master_model_inst.build(ADDR, mdh_pkg::FC_DIAG, sub, dat);
      if (exc)
      begin
         mdh_master_model_inst.frm[1] =
            mdh_pkg::FC_DIAG | mdh_pkg::FC_EXC_FLAG;
         mdh_master_model_inst.frm[2] = mdh_pkg::EXC_ILLEGAL_FUNCTION;
         c = mdh_master_model_inst.crc16(3);
         mdh_master_model_inst.frm[3] = c[7:0];
         mdh_master_model_inst.frm[4] = c[15:8];
      end
      for (int t = 0; t < 200 && mdh_master_model_inst.got.size() < n; t++)
         @(posedge mclk);
      repeat (4) @(posedge mclk);
      `chk("reply length", mdh_master_model_inst.got.size(), n)
      for (int i = 0; i < n && i < mdh_master_model_inst.got.size(); i++)
      begin
         got_b = mdh_master_model_inst.got[i];
         exp_b = mdh_master_model_inst.frm[i];
         `chk("reply byte", got_b, exp_b)
      end
   endtask

   // a dropped request leaves the reply side silent
   task automatic none();
      repeat (16) @(posedge mclk);
      `chk("no reply", mdh_master_model_inst.got.size(), 0)
   endtask

   // hang guard, far beyond the few hundred cycles of the run
   initial
   begin
      #200000;
      fails++;
      stop_test();
   end

   // main sequence
   initial
   begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      `chk("diag reset", diag_status, mdh_pkg::DIAG_STATUS_RESET)
      `chk("count reset", crc_error_count, mdh_pkg::CRC_ERR_RESET)
      req(mdh_pkg::SUB_LOOPBACK, 16'h00fd, ADDR, 1'b0);
      reply(mdh_pkg::SUB_LOOPBACK, 16'h00fd, 1'b0);
      mdh_master_model_inst.slow <= 1'b1;
      req(mdh_pkg::SUB_LOOPBACK, 16'ha55a, ADDR, 1'b0);
      reply(mdh_pkg::SUB_LOOPBACK, 16'ha55a, 1'b0);
      mdh_master_model_inst.slow <= 1'b0;
      repeat (2)
      begin
         req(mdh_pkg::SUB_LOOPBACK, 16'h0000, ADDR, 1'b1);
         none();
      end
      req(mdh_pkg::SUB_LOOPBACK, 16'h0000, ADDR + 8'h01, 1'b0);
      none();
      req(mdh_pkg::SUB_CRC_ERRORS, 16'h0000, ADDR, 1'b0);
      reply(mdh_pkg::SUB_CRC_ERRORS, 16'h0002, 1'b0);
      diag_set <= 16'h2100;
      @(posedge mclk);
      diag_set <= 16'h0000;
      req(mdh_pkg::SUB_DIAG_REG, 16'h0000, ADDR, 1'b0);
      reply(mdh_pkg::SUB_DIAG_REG, 16'h2100, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         req(BAD_SUB[i], 16'h0000, ADDR, 1'b0);
         reply(BAD_SUB[i], 16'h0000, 1'b1);
      end
      `chk("no action diag", diag_status, 16'h2100)
      `chk("no action clear", clr_cnt, 0)
      diag_set <= 16'h0001;
      req(mdh_pkg::SUB_CLEAR, 16'h0000, ADDR, 1'b0);
      reply(mdh_pkg::SUB_CLEAR, 16'h0000, 1'b0);
      `chk("diag after clear", diag_status, 16'h0001)
      `chk("count after clear", crc_error_count, 16'h0000)
      `chk("clear pulses", clr_cnt, 1)
      diag_set <= 16'h0000;
      req(mdh_pkg::SUB_LOOPBACK, 16'h0000, ADDR, 1'b1);
      none();
      req(mdh_pkg::SUB_RESTART, 16'h0000, ADDR, 1'b0);
      reply(mdh_pkg::SUB_RESTART, 16'h0000, 1'b0);
      req(mdh_pkg::SUB_LOOPBACK, 16'h1234, ADDR, 1'b0);
      none();
      `chk("reinit over", comm_reinit, 1'b0)
      `chk("restart pulses", clr_cnt, 2)
      req(mdh_pkg::SUB_CRC_ERRORS, 16'h0000, ADDR, 1'b0);
      reply(mdh_pkg::SUB_CRC_ERRORS, 16'h0000, 1'b0);
      stop_test();
   end
endmodule

`default_nettype wire
